// ---- common/pivb_pkg.sv ----
// Purpose: shared constants and types of the peripheral interrupt vector builder
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes:   vectors are 32 bits wide, source identifier in the top nibble
package pivb_pkg;

  localparam int          CLOCK_MHZ      = 20;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;

  // register byte addresses
  localparam logic [7:0]  ADDR_CONFIG    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_MASK      = 8'h08;
  localparam logic [7:0]  ADDR_PENDING   = 8'h0C;

  // config fields and reset values
  localparam int          CFG_POL_BIT    = 0;
  localparam logic        CFG_POL_RESET  = 1'b1;

  // interrupt status / mask layout
  localparam int          IRQ_W          = 3;
  localparam int          IRQ_SENT_BIT   = 0;
  localparam int          IRQ_MERGE_BIT  = 1;
  localparam int          IRQ_STALL_BIT  = 2;
  localparam logic [2:0]  MASK_RESET     = 3'h0;

  // pending sources, index order is priority order, lowest index first
  localparam int          SRC_N          = 5;
  localparam int          SRC_ERR        = 0;
  localparam int          SRC_RX         = 1;
  localparam int          SRC_TX         = 2;
  localparam int          SRC_LBI        = 3;
  localparam int          SRC_GPP        = 4;

  // source identifiers
  localparam logic [3:0]  ID_SERIAL      = 4'hC;
  localparam logic [3:0]  ID_LOCAL       = 4'hD;
  localparam logic [3:0]  ID_PORT        = 4'hF;

  localparam logic [15:0] PAYLOAD_ZERO   = 16'h0000;

  typedef struct packed {
    logic [3:0]  source_id;   // 31..28
    logic [2:0]  zero_hi;     // 27..25
    logic        rx_tx;       // 24, one for receive
    logic        data_err;    // 23, one for data
    logic [3:0]  zero_mid;    // 22..19
    logic        err_flag;    // 18
    logic        rx_flag;     // 17
    logic        tx_flag;     // 16
    logic [15:0] status_word_payload;
  } pivb_vector_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pivb_bus_t;

endpackage

// ---- verilog/pivb_top.sv ----
// Purpose: builds peripheral interrupt vectors and hands them to the queue writer
// Assumes: serial event strobes and words come from logic on this clock
// Notes:   one vector per cycle at most; a repeat event of a source
//          still pending merges into that pending vector
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module pivb_top
  import pivb_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic [ADDR_W-1:0]  bus_addr,
  input  wire logic [DATA_W-1:0]  bus_wdata,
  input  wire logic               bus_wr,
  input  wire logic               bus_rd,
  output logic      [DATA_W-1:0]  bus_rdata,
  input  wire logic               serial_rx_event,
  input  wire logic               serial_tx_event,
  input  wire logic               serial_err_event,
  input  wire logic [15:0]        serial_rx_buffer,
  input  wire logic [15:0]        serial_control_word,
  input  wire logic               local_irq_input_one,
  input  wire logic [15:0]        port_pin_levels,
  output logic                    vector_valid,
  output pivb_vector_t            vector_data,
  input  wire logic               queue_ready,
  output logic                    irq
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  logic        lbi_s1_reg, lbi_s2_reg, lbi_s3_reg;
  logic [15:0] gpp_s1_reg, gpp_s2_reg, gpp_s3_reg;
  logic        local_irq_polarity_sel;
  logic        lbi_edge;
  logic        gpp_change;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      lbi_s1_reg <= 1'b0;
      lbi_s2_reg <= 1'b0;
      lbi_s3_reg <= 1'b0;
      gpp_s1_reg <= 16'h0000;
      gpp_s2_reg <= 16'h0000;
      gpp_s3_reg <= 16'h0000;
    end
    else
    begin
      lbi_s1_reg <= local_irq_input_one;
      lbi_s2_reg <= lbi_s1_reg;
      lbi_s3_reg <= lbi_s2_reg;
      gpp_s1_reg <= port_pin_levels;
      gpp_s2_reg <= gpp_s1_reg;
      gpp_s3_reg <= gpp_s2_reg;
    end
  end

  // edge taken on the raw level, so flipping polarity alone makes no event
  always_comb
  begin
    if (local_irq_polarity_sel)
      lbi_edge = lbi_s2_reg & ~lbi_s3_reg;
    else
      lbi_edge = ~lbi_s2_reg & lbi_s3_reg;
    gpp_change = (gpp_s2_reg != gpp_s3_reg);
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending events, captured payloads, priority pick

  logic [SRC_N-1:0] pend_reg, pend_next;
  logic [15:0]      rx_pay_reg, rx_pay_next;
  logic [15:0]      err_pay_reg, err_pay_next;
  logic [15:0]      gpp_pay_reg, gpp_pay_next;
  logic [SRC_N-1:0] new_events;
  logic [SRC_N-1:0] grant_vec;
  logic             load;

  function automatic logic [SRC_N-1:0] pick_first(input logic [SRC_N-1:0] req);
    logic [SRC_N-1:0] g;
    g = '0;
    for (int i = SRC_N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        g = '0;
        g[i] = 1'b1;
      end
    end
    return g;
  endfunction

  always_comb
  begin
    new_events          = '0;
    new_events[SRC_ERR] = serial_err_event;
    new_events[SRC_RX]  = serial_rx_event;
    new_events[SRC_TX]  = serial_tx_event;
    new_events[SRC_LBI] = lbi_edge;
    new_events[SRC_GPP] = gpp_change;
    load       = ~vector_valid | queue_ready;
    grant_vec  = load ? pick_first(pend_reg) : '0;
    // a new event wins over the grant that retires the same source
    pend_next  = (pend_reg & ~grant_vec) | new_events;
    rx_pay_next  = serial_rx_event  ? serial_rx_buffer    : rx_pay_reg;
    err_pay_next = serial_err_event ? serial_control_word : err_pay_reg;
    gpp_pay_next = gpp_change       ? gpp_s2_reg          : gpp_pay_reg;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pend_reg    <= '0;
      rx_pay_reg  <= 16'h0000;
      err_pay_reg <= 16'h0000;
      gpp_pay_reg <= 16'h0000;
    end
    else
    begin
      pend_reg    <= pend_next;
      rx_pay_reg  <= rx_pay_next;
      err_pay_reg <= err_pay_next;
      gpp_pay_reg <= gpp_pay_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vector build and queue handshake

  pivb_vector_t vec_reg, vec_next;
  logic         valid_reg, valid_next;
  pivb_vector_t built;

  always_comb
  begin
    built = '0;
    if (grant_vec[SRC_ERR])
    begin
      built.source_id           = ID_SERIAL;
      built.data_err            = 1'b0;
      built.err_flag            = 1'b1;
      built.status_word_payload = err_pay_reg;
    end
    else if (grant_vec[SRC_RX])
    begin
      built.source_id           = ID_SERIAL;
      built.rx_tx               = 1'b1;
      built.data_err            = 1'b1;
      built.rx_flag             = 1'b1;
      built.status_word_payload = rx_pay_reg;
    end
    else if (grant_vec[SRC_TX])
    begin
      built.source_id           = ID_SERIAL;
      built.data_err            = 1'b1;
      built.tx_flag             = 1'b1;
      built.status_word_payload = PAYLOAD_ZERO;
    end
    else if (grant_vec[SRC_LBI])
    begin
      built.source_id = ID_LOCAL;
    end
    else if (grant_vec[SRC_GPP])
    begin
      built.source_id           = ID_PORT;
      built.status_word_payload = gpp_pay_reg;
    end
    if (load)
    begin
      valid_next = |grant_vec;
      vec_next   = (|grant_vec) ? built : vec_reg;
    end
    else
    begin
      valid_next = valid_reg;
      vec_next   = vec_reg;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      vec_reg   <= '0;
      valid_reg <= 1'b0;
    end
    else
    begin
      vec_reg   <= vec_next;
      valid_reg <= valid_next;
    end
  end

  assign vector_valid = valid_reg;
  assign vector_data  = vec_reg;

  ////////////////////////////////////////////////////////////////////////////
  // software registers and interrupt

  logic             pol_reg, pol_next;
  logic [IRQ_W-1:0] status_reg, status_next;
  logic [IRQ_W-1:0] mask_reg, mask_next;
  logic [31:0]      rdata_reg, rdata_next;
  logic             irq_reg, irq_next;
  logic [IRQ_W-1:0] irq_events;

  assign local_irq_polarity_sel = pol_reg;

  always_comb
  begin
    irq_events                = '0;
    irq_events[IRQ_SENT_BIT]  = valid_reg & queue_ready;
    irq_events[IRQ_MERGE_BIT] = |(pend_reg & ~grant_vec & new_events);
    irq_events[IRQ_STALL_BIT] = valid_reg & ~queue_ready & (|pend_reg);
    pol_next    = pol_reg;
    mask_next   = mask_reg;
    status_next = status_reg;
    if (bus_wr && bus_addr == ADDR_CONFIG)
      pol_next = bus_wdata[CFG_POL_BIT];
    if (bus_wr && bus_addr == ADDR_MASK)
      mask_next = bus_wdata[IRQ_W-1:0];
    if (bus_wr && bus_addr == ADDR_STATUS)
      status_next = status_reg & ~bus_wdata[IRQ_W-1:0];
    // set wins over a write-one clear in the same cycle
    status_next = status_next | irq_events;
    rdata_next  = 32'h0000_0000;
    if (bus_rd)
    begin
      case (bus_addr)
        ADDR_CONFIG:  rdata_next = {31'h0000_0000, pol_reg};
        ADDR_STATUS:  rdata_next = {29'h0000_0000, status_reg};
        ADDR_MASK:    rdata_next = {29'h0000_0000, mask_reg};
        ADDR_PENDING: rdata_next = {27'h0000_0000, pend_reg};
        default:      rdata_next = 32'h0000_0000;
      endcase
    end
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pol_reg    <= CFG_POL_RESET;
      status_reg <= '0;
      mask_reg   <= MASK_RESET;
      rdata_reg  <= 32'h0000_0000;
      irq_reg    <= 1'b0;
    end
    else
    begin
      pol_reg    <= pol_next;
      status_reg <= status_next;
      mask_reg   <= mask_next;
      rdata_reg  <= rdata_next;
      irq_reg    <= irq_next;
    end
  end

  assign bus_rdata = rdata_reg;
  assign irq       = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_local_vector_zero: assert property (@(posedge clock) disable iff (rst)
    valid_reg && vec_reg.source_id == ID_LOCAL |-> vec_reg[27:0] == 28'h0000000)
    else $error("local bus vector carries payload");

  a_port_vector_form: assert property (@(posedge clock) disable iff (rst)
    valid_reg && vec_reg.source_id == ID_PORT |-> vec_reg[27:16] == 12'h000)
    else $error("port vector upper bits not zero");

  a_tx_payload_zero: assert property (@(posedge clock) disable iff (rst)
    valid_reg && vec_reg.tx_flag |-> vec_reg.status_word_payload == 16'h0000
      && !vec_reg.rx_flag && !vec_reg.rx_tx)
    else $error("transmit vector payload not zero");

  a_flag_indicators: assert property (@(posedge clock) disable iff (rst)
    valid_reg && vec_reg.source_id == ID_SERIAL |->
      vec_reg.rx_flag == (vec_reg.rx_tx && vec_reg.data_err)
      && vec_reg.err_flag == !vec_reg.data_err)
    else $error("serial flags disagree with indicators");

  a_rx_payload_copy: assert property (@(posedge clock) disable iff (rst)
    serial_rx_event && !serial_err_event && pend_reg == '0 && !valid_reg
      |=> ##1 valid_reg && vec_reg.rx_flag
        && vec_reg.status_word_payload == $past(serial_rx_buffer, 2))
    else $error("receive vector payload wrong");

  a_err_payload_copy: assert property (@(posedge clock) disable iff (rst)
    serial_err_event && pend_reg == '0 && !valid_reg |=> ##1 valid_reg && vec_reg.err_flag
      && vec_reg.status_word_payload == $past(serial_control_word, 2))
    else $error("error vector payload wrong");

  a_local_edge_pend: assert property (@(posedge clock) disable iff (rst)
    (pol_reg ? $rose(lbi_s2_reg) : $fell(lbi_s2_reg)) |=> pend_reg[SRC_LBI])
    else $error("local input edge not pending");

  a_port_change_cap: assert property (@(posedge clock) disable iff (rst)
    gpp_change |=> pend_reg[SRC_GPP] && gpp_pay_reg == $past(gpp_s2_reg))
    else $error("port change not captured");

  a_pend_no_loss: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> (pend_reg & $past(pend_reg & ~grant_vec)) == $past(pend_reg & ~grant_vec))
    else $error("pending event lost");

  a_vector_hold: assert property (@(posedge clock) disable iff (rst)
    valid_reg && !queue_ready |=> valid_reg && $stable(vec_reg))
    else $error("vector changed while stalled");

  a_serial_ident: assert property (@(posedge clock) disable iff (rst)
    valid_reg && (vec_reg.rx_flag || vec_reg.tx_flag || vec_reg.err_flag)
      |-> vec_reg.source_id == ID_SERIAL && vec_reg[27:25] == 3'h0)
    else $error("serial vector identifier wrong");

endmodule

// ---- verif/pivb_top_tb.sv ----
// Purpose: self-checking bench for the peripheral interrupt vector builder
// Assumes: 20 MHz clock, synchronous active-high reset held for 5 cycles
// Notes:   inputs change by non-blocking assignment at the rising edge,
//          outputs are sampled at the falling edge where they have settled
`timescale 1ns/100ps
module pivb_top_tb
  import pivb_pkg::*;
;
  logic                clock;
  logic                rst;
  logic [ADDR_W-1:0]   bus_addr;
  logic [DATA_W-1:0]   bus_wdata;
  logic                bus_wr;
  logic                bus_rd;
  logic [DATA_W-1:0]   bus_rdata;
  logic                serial_rx_event;
  logic                serial_tx_event;
  logic                serial_err_event;
  logic [15:0]         serial_rx_buffer;
  logic [15:0]         serial_control_word;
  logic                local_irq_input_one;
  logic [15:0]         port_pin_levels;
  logic                vector_valid;
  pivb_vector_t        vector_data;
  logic                queue_ready;
  logic                irq;
  int                  error_cnt;
  int                  cmp_count;
  logic [31:0]         rd_val;

  pivb_top pivb_top_i (
    .clock               (clock),
    .rst                 (rst),
    .bus_addr            (bus_addr),
    .bus_wdata           (bus_wdata),
    .bus_wr              (bus_wr),
    .bus_rd              (bus_rd),
    .bus_rdata           (bus_rdata),
    .serial_rx_event     (serial_rx_event),
    .serial_tx_event     (serial_tx_event),
    .serial_err_event    (serial_err_event),
    .serial_rx_buffer    (serial_rx_buffer),
    .serial_control_word (serial_control_word),
    .local_irq_input_one (local_irq_input_one),
    .port_pin_levels     (port_pin_levels),
    .vector_valid        (vector_valid),
    .vector_data         (vector_data),
    .queue_ready         (queue_ready),
    .irq                 (irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clock);
    bus_wr    <= 1'b0;
  endtask

  // read data only stand in the cycle after the read strobe
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clock);
    bus_rd   <= 1'b0;
    @(negedge clock);
    d = bus_rdata;
  endtask

  task automatic serial_pulse(input logic r, input logic t, input logic e);
    @(posedge clock);
    serial_rx_event  <= r;
    serial_tx_event  <= t;
    serial_err_event <= e;
    @(posedge clock);
    serial_rx_event  <= 1'b0;
    serial_tx_event  <= 1'b0;
    serial_err_event <= 1'b0;
  endtask

  function automatic logic [31:0] mkv(input logic [3:0] id, input logic rt, input logic de,
                                      input logic [2:0] flags, input logic [15:0] pay);
    pivb_vector_t v;
    v = '0;
    v.source_id = id;
    v.rx_tx = rt;
    v.data_err = de;
    {v.err_flag, v.rx_flag, v.tx_flag} = flags;
    v.status_word_payload = pay;
    return v;
  endfunction

  // wait for a vector under a bound, compare it, then accept it for one edge
  task automatic take_vec(input string name, input logic [31:0] exp);
    int n;
    n = 0;
    @(negedge clock);
    while (vector_valid !== 1'b1 && n < 20)
    begin
      n++;
      @(negedge clock);
    end
    check({name, " valid"}, {31'h0, vector_valid}, 32'h1);
    check(name, vector_data, exp);
    @(posedge clock);
    queue_ready <= 1'b1;
    @(posedge clock);
    queue_ready <= 1'b0;
  endtask

  task automatic quiet(input string name, input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) @(negedge clock) seen |= vector_valid;
    check(name, {31'h0, seen}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    serial_rx_event = 1'b0;
    serial_tx_event = 1'b0;
    serial_err_event = 1'b0;
    serial_rx_buffer = 16'h0000;
    serial_control_word = 16'h0000;
    local_irq_input_one = 1'b0;
    port_pin_levels = 16'h0000;
    queue_ready = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);

    bus_read(ADDR_CONFIG, rd_val);
    check("config reset", rd_val, 32'h1);
    bus_read(ADDR_MASK, rd_val);
    check("mask reset", rd_val, 32'h0);
    bus_read(8'h10, rd_val);
    check("unmapped read", rd_val, 32'h0);
    $display("test registers done");

    @(posedge clock);
    serial_rx_buffer <= 16'hA55A;
    serial_control_word <= 16'h1234;
    serial_pulse(1'b1, 1'b0, 1'b0);
    take_vec("rx vector", mkv(4'hC, 1'b1, 1'b1, 3'b010, 16'hA55A));
    serial_pulse(1'b0, 1'b1, 1'b0);
    take_vec("tx vector", mkv(4'hC, 1'b0, 1'b1, 3'b001, 16'h0000));
    serial_pulse(1'b0, 1'b0, 1'b1);
    take_vec("err vector", mkv(4'hC, 1'b0, 1'b0, 3'b100, 16'h1234));
    $display("test serial done");

    serial_rx_buffer <= 16'h00FF;
    serial_pulse(1'b1, 1'b1, 1'b1);
    serial_rx_buffer <= 16'h7E7E;
    take_vec("first of three", mkv(4'hC, 1'b0, 1'b0, 3'b100, 16'h1234));
    take_vec("second of three", mkv(4'hC, 1'b1, 1'b1, 3'b010, 16'h00FF));
    take_vec("third of three", mkv(4'hC, 1'b0, 1'b1, 3'b001, 16'h0000));
    quiet("nothing after three", 8);
    $display("test priority done");

    @(posedge clock);
    local_irq_input_one <= 1'b1;
    take_vec("local rising", 32'hD000_0000);
    quiet("local held", 10);
    bus_write(ADDR_CONFIG, 32'h0);
    quiet("polarity change", 8);
    @(posedge clock);
    local_irq_input_one <= 1'b0;
    take_vec("local falling low active", 32'hD000_0000);
    @(posedge clock);
    local_irq_input_one <= 1'b1;
    quiet("local release", 10);
    $display("test local done");

    @(posedge clock);
    port_pin_levels <= 16'h8001;
    take_vec("port change", mkv(4'hF, 1'b0, 1'b0, 3'b000, 16'h8001));
    quiet("port steady", 8);
    @(posedge clock);
    port_pin_levels <= 16'h8000;
    take_vec("port one pin", mkv(4'hF, 1'b0, 1'b0, 3'b000, 16'h8000));
    $display("test port done");

    // third receive lands while the second is still pending: it merges, latest payload kept
    serial_rx_buffer <= 16'h1111;
    serial_pulse(1'b1, 1'b0, 1'b0);
    serial_rx_buffer <= 16'h2222;
    serial_pulse(1'b1, 1'b0, 1'b0);
    serial_rx_buffer <= 16'h3333;
    serial_pulse(1'b1, 1'b0, 1'b0);
    take_vec("before merge", mkv(4'hC, 1'b1, 1'b1, 3'b010, 16'h1111));
    take_vec("merged rx", mkv(4'hC, 1'b1, 1'b1, 3'b010, 16'h3333));
    quiet("nothing after merge", 8);
    $display("test merge done");

    // sent, merged and stall bits have all been raised by the traffic above
    bus_read(ADDR_STATUS, rd_val);
    check("status events", rd_val, 32'h7);
    check("irq masked", {31'h0, irq}, 32'h0);
    bus_write(ADDR_MASK, 32'h1);
    repeat (3) @(negedge clock);
    check("irq unmasked", {31'h0, irq}, 32'h1);
    bus_write(ADDR_STATUS, 32'h7);
    repeat (3) @(negedge clock);
    check("irq cleared", {31'h0, irq}, 32'h0);
    bus_read(ADDR_STATUS, rd_val);
    check("status cleared", rd_val, 32'h0);
    bus_read(ADDR_PENDING, rd_val);
    check("pending empty", rd_val, 32'h0);
    $display("test interrupt done");
    conclude();
  end

  // the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    conclude();
  end
endmodule
